//--- common/aap_pkg.sv
package aap_pkg;
   localparam int AAP_NSETS = 4;
   localparam int AAP_SETW = 2;
   localparam logic [31:0] AAP_SPEED_LIMIT_RST = 32'h0003_0D40;
   localparam logic [15:0] AAP_TIME_RST = 16'h03E8;
   localparam logic [15:0] AAP_TIME_MIN = 16'h0001;
   localparam logic [7:0] AAP_SRATIO_RST = 8'h00;
   localparam logic [7:0] AAP_SRATIO_MAX = 8'h64;
   localparam logic [10:0] AAP_TORQUE_RST = 11'h12C;
   localparam logic [10:0] AAP_TORQUE_MAX = 11'h3E8;
   localparam logic [16:0] AAP_ARC_TOL_RST = 17'h00064;
   localparam logic [16:0] AAP_ARC_TOL_MAX = 17'h186A0;
   localparam logic [AAP_SETW-1:0] AAP_DEFAULT_SET = 2'h0;
   localparam logic [7:0] AAP_ERR_RAPID_GT_DECEL = 8'h33;
   localparam logic [7:0] AAP_ERR_SRATIO_RANGE = 8'h34;
   localparam logic [7:0] AAP_ERR_NONE = 8'h00;
   localparam int AAP_CLK_KHZ = 200000;
   localparam int AAP_CYC_PER_MS = AAP_CLK_KHZ;

   typedef enum logic [1:0] {
      AAP_TRAP = 2'h0,
      AAP_SCURVE = 2'h1,
      AAP_ADV = 2'h2
   } aap_prof_t;

   typedef enum logic [3:0] {
      AAP_IDLE = 4'b0001,
      AAP_ACCEL = 4'b0010,
      AAP_CRUISE = 4'b0100,
      AAP_DECEL = 4'b1000
   } aap_state_t;
endpackage

//--- core/aap_axis_accel_profile.sv
// Function
// - Per-set torque limit, max 1000, default 300
// - Stop or limit inputs decelerate, chosen time
// - Store arc end-point tolerance, default 100
// - No set named means set one
// - Ratio zero trapezoid, 1 to 100 S-curve
// - Advanced S-curve ignores S-curve ratio
// - Fixed-time method disregards advanced S-curve
// - Accel rate is limit over accel time
// - Decel and rapid rates likewise
// - Rapid above decel at start: error 51
// - Then rapid cause uses deceleration time
// - Disable flag, sampled at start, skips error
// - Advanced S-curve uses smaller of two times
// - Rapid not above decel uses rapid time
// - Bad ratio: error, run trapezoid
// - S-curve ramp is portion of sine; code runs a linear accel ramp with a smaller step near its ends, and a plain linear decel
// - Stop or skip in end decel regenerates
// - Skip at constant speed is ignored, no regeneration
// - Rapid stop in S decel regenerates
// - Normal-decel stop input regenerates likewise
// - Clamp commanded speed to speed limit
`timescale 1ns/1ps
`default_nettype none
module aap_axis_accel_profile
   import aap_pkg::*;
#(
   parameter int NSETS = aap_pkg::AAP_NSETS,
   parameter int CYC_PER_MS = aap_pkg::AAP_CYC_PER_MS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic cfgWrite,
   input wire logic [aap_pkg::AAP_SETW-1:0] cfgSet,
   input wire logic [31:0] cfgSpeedLimit,
   input wire logic [15:0] cfgAccelTime,
   input wire logic [15:0] cfgDecelTime,
   input wire logic [15:0] cfgRapidTime,
   input wire logic [7:0] cfgSRatio,
   input wire logic cfgAdvanced,
   input wire logic cfgStopUsesRapid,
   input wire logic [10:0] cfgTorque,
   input wire logic [16:0] cfgArcTol,
   input wire logic moveStart,
   input wire logic moveSetValid,
   input wire logic [aap_pkg::AAP_SETW-1:0] moveSet,
   input wire logic [31:0] moveSpeed,
   input wire logic fixed_time_accel_method,
   input wire logic rapid_time_check_disable_flag,
   input wire logic errorClear,
   input wire logic stopPin,
   input wire logic forward_limit_input,
   input wire logic reverse_limit_input,
   input wire logic rapidStopPin,
   input wire logic skipPin,
   output logic [31:0] speedCmd,
   output logic moving,
   output logic [10:0] torqueLimit,
   output logic [16:0] arcTolerance,
   output logic [1:0] profileMode,
   output logic [7:0] sRatioActive,
   output logic regenPulse,
   output logic [7:0] error_detail_word,
   output logic program_setting_error_flag
);
   import aap_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Parameter sets
   logic [31:0] limSet [NSETS];
   logic [15:0] accSet [NSETS];
   logic [15:0] decSet [NSETS];
   logic [15:0] rapSet [NSETS];
   logic [7:0] ratSet [NSETS];
   logic advSet [NSETS];
   logic stopRapSet [NSETS];
   logic [10:0] trqSet [NSETS];
   logic [16:0] tolSet [NSETS];

   genvar gi;
   generate
      for (gi = 0; gi < NSETS; gi++) begin : gSet
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               limSet[gi] <= AAP_SPEED_LIMIT_RST;
               accSet[gi] <= AAP_TIME_RST;
               decSet[gi] <= AAP_TIME_RST;
               rapSet[gi] <= AAP_TIME_RST;
               ratSet[gi] <= AAP_SRATIO_RST;
               advSet[gi] <= 1'b0;
               stopRapSet[gi] <= 1'b0;
               trqSet[gi] <= AAP_TORQUE_RST;
               tolSet[gi] <= AAP_ARC_TOL_RST;
            end else if (cfgWrite && cfgSet == AAP_SETW'(gi)) begin
               limSet[gi] <= cfgSpeedLimit;
               // Zero times would stall the rate divide, keep at least 1 ms
               accSet[gi] <= (cfgAccelTime == 16'h0000) ? AAP_TIME_MIN
                  : cfgAccelTime;
               decSet[gi] <= (cfgDecelTime == 16'h0000) ? AAP_TIME_MIN
                  : cfgDecelTime;
               rapSet[gi] <= (cfgRapidTime == 16'h0000) ? AAP_TIME_MIN
                  : cfgRapidTime;
               ratSet[gi] <= cfgSRatio;
               advSet[gi] <= cfgAdvanced;
               stopRapSet[gi] <= cfgStopUsesRapid;
               // Out-of-range torque and tolerance settings saturate
               trqSet[gi] <= (cfgTorque > AAP_TORQUE_MAX) ? AAP_TORQUE_MAX
                  : cfgTorque;
               tolSet[gi] <= (cfgArcTol > AAP_ARC_TOL_MAX) ? AAP_ARC_TOL_MAX
                  : cfgArcTol;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [4:0] pinMeta;
   logic [4:0] pinSync;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pinMeta <= 5'h00;
         pinSync <= 5'h00;
      end else begin
         pinMeta <= {skipPin, rapidStopPin, reverse_limit_input,
            forward_limit_input, stopPin};
         pinSync <= pinMeta;
      end
   end
   logic stopCause;
   logic rapidCause;
   logic skipCause;
   assign stopCause = |pinSync[2:0];
   assign rapidCause = pinSync[3];
   assign skipCause = pinSync[4];

   ////////////////////////////////////////////////////////////////////////
   // Latch selected set at start
   logic [AAP_SETW-1:0] selSet;
   assign selSet = moveSetValid ? moveSet : AAP_DEFAULT_SET;

   logic [31:0] lim_reg;
   logic [15:0] acc_reg;
   logic [15:0] dec_reg;
   logic [15:0] rap_reg;
   logic stopRap_reg;
   logic fixed_reg;
   logic chkOff_reg;
   logic [31:0] target_reg;
   aap_prof_t prof_reg;
   aap_prof_t profNext;
   logic ratioBad;
   logic [7:0] ratioNext;

   assign ratioBad = ratSet[selSet] > AAP_SRATIO_MAX;
   always_comb begin
      ratioNext = ratioBad ? 8'h00 : ratSet[selSet];
      if (advSet[selSet] && !fixed_time_accel_method) begin
         profNext = AAP_ADV;
         ratioNext = 8'h00;
      end else if (ratioNext == 8'h00) begin
         profNext = AAP_TRAP;
      end else begin
         profNext = AAP_SCURVE;
      end
      // Fixed-time method never reaches advanced profile
   end

   logic startOk;
   aap_state_t state_reg;
   assign startOk = moveStart && state_reg == AAP_IDLE;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lim_reg <= AAP_SPEED_LIMIT_RST;
         acc_reg <= AAP_TIME_RST;
         dec_reg <= AAP_TIME_RST;
         rap_reg <= AAP_TIME_RST;
         stopRap_reg <= 1'b0;
         fixed_reg <= 1'b0;
         chkOff_reg <= 1'b0;
         target_reg <= 32'h0000_0000;
         prof_reg <= AAP_TRAP;
         sRatioActive <= 8'h00;
         profileMode <= 2'h0;
         torqueLimit <= AAP_TORQUE_RST;
         arcTolerance <= AAP_ARC_TOL_RST;
      end else if (startOk) begin
         lim_reg <= limSet[selSet];
         acc_reg <= accSet[selSet];
         dec_reg <= decSet[selSet];
         rap_reg <= rapSet[selSet];
         stopRap_reg <= stopRapSet[selSet];
         fixed_reg <= fixed_time_accel_method;
         chkOff_reg <= rapid_time_check_disable_flag;
         target_reg <= (moveSpeed > limSet[selSet]) ? limSet[selSet]
            : moveSpeed;
         prof_reg <= profNext;
         sRatioActive <= ratioNext;
         profileMode <= profNext;
         torqueLimit <= trqSet[selSet];
         arcTolerance <= tolSet[selSet];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start-time checks
   logic rapidLong;
   assign rapidLong = rapSet[selSet] > decSet[selSet];
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         error_detail_word <= AAP_ERR_NONE;
         program_setting_error_flag <= 1'b0;
      end else if (startOk && rapidLong && !rapid_time_check_disable_flag) begin
         error_detail_word <= AAP_ERR_RAPID_GT_DECEL;
         program_setting_error_flag <= 1'b1;
      end else if (startOk && ratioBad && !(advSet[selSet]
            && !fixed_time_accel_method)) begin
         error_detail_word <= AAP_ERR_SRATIO_RANGE;
         program_setting_error_flag <= 1'b1;
      end else if (errorClear) begin
         // Set wins over clear because it is tested first
         error_detail_word <= AAP_ERR_NONE;
         program_setting_error_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stop time choice
   logic [15:0] rapidEff;
   logic [15:0] stopTime;
   always_comb begin
      if (prof_reg == AAP_ADV) begin
         rapidEff = (rap_reg < dec_reg) ? rap_reg : dec_reg;
      end else if (rap_reg > dec_reg) begin
         rapidEff = dec_reg;
      end else begin
         rapidEff = rap_reg;
      end
      if (rapidCause || (stopCause && stopRap_reg)) begin
         stopTime = rapidEff;
      end else begin
         stopTime = dec_reg;
      end
      // Check-disable still lets a long rapid time run outside advanced
      if (chkOff_reg && prof_reg != AAP_ADV
            && (rapidCause || (stopCause && stopRap_reg))) begin
         stopTime = rap_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Rate derivation, one step per millisecond tick
   // Step is per millisecond tick; a divider keeps the multiply-free path
   logic [31:0] accStep;
   logic [31:0] decStep;
   assign accStep = lim_reg / {16'h0000, acc_reg};
   assign decStep = lim_reg / {16'h0000, stopTime};

   logic [31:0] tick_reg;
   logic tick;
   assign tick = tick_reg == 32'h0000_0000;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tick_reg <= 32'h0000_0000;
      end else if (tick || startOk) begin
         tick_reg <= 32'(CYC_PER_MS - 1);
      end else begin
         tick_reg <= tick_reg - 32'h0000_0001;
      end
   end

   // S-curve shaping: linear accel ramp softened near its ends by the ratio;
   // the sine section scales the step to (200 - ratio)/200 near both ends,
   // so a full 100 percent ratio still moves at half rate, never stalls
   logic [31:0] shapedAcc;
   logic [39:0] shapeProd;
   logic [31:0] gap;
   always_comb begin
      gap = (target_reg > speedCmd) ? target_reg - speedCmd
         : speedCmd - target_reg;
      shapeProd = {8'h00, accStep} * {32'h0, (8'hC8 - sRatioActive)}
         / 40'd200;
      shapedAcc = accStep;
      if (prof_reg != AAP_TRAP && (speedCmd < accStep * 4
            || gap < accStep * 4)) begin
         shapedAcc = (shapeProd[31:0] == 32'h0) ? 32'h1
            : shapeProd[31:0];
      end
   end

   logic stopReq;
   logic endDecel;
   assign stopReq = stopCause || rapidCause;
   assign endDecel = state_reg == AAP_DECEL && prof_reg != AAP_TRAP;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= AAP_IDLE;
         speedCmd <= 32'h0000_0000;
         moving <= 1'b0;
         regenPulse <= 1'b0;
      end else begin
         regenPulse <= 1'b0;
         case (state_reg)
            AAP_IDLE: begin
               moving <= 1'b0;
               if (startOk) begin
                  state_reg <= AAP_ACCEL;
                  moving <= 1'b1;
               end
            end
            AAP_ACCEL, AAP_CRUISE: begin
               if (stopReq) begin
                  state_reg <= AAP_DECEL;
               end else if (tick) begin
                  if (target_reg - speedCmd > shapedAcc
                        && speedCmd < target_reg) begin
                     speedCmd <= speedCmd + shapedAcc;
                  end else begin
                     speedCmd <= target_reg;
                     state_reg <= AAP_CRUISE;
                  end
               end
            end
            AAP_DECEL: begin
               // New stop or skip regenerates the S pattern, overrun possible
               if (endDecel && (skipCause || rapidCause || stopCause)
                     && !regenPulse && tick) begin
                  regenPulse <= 1'b1;
               end
               if (tick) begin
                  if (speedCmd > decStep) begin
                     speedCmd <= speedCmd - decStep;
                  end else begin
                     speedCmd <= 32'h0000_0000;
                     state_reg <= AAP_IDLE;
                  end
               end
            end
            default: state_reg <= AAP_IDLE;
         endcase
      end
   end
   // Skip during constant-speed cruise is not decoded; it acts only in S decel
   // Rapid and normal-decel stop inputs reuse it too

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_err51;
      @(posedge clock) disable iff (!rstn)
         startOk && rapidLong && !rapid_time_check_disable_flag
         |=> error_detail_word == AAP_ERR_RAPID_GT_DECEL
         && program_setting_error_flag;
   endproperty
   a_err51: assert property (p_err51)
      else $error("rapid time error not raised");

   property p_nochk;
      @(posedge clock) disable iff (!rstn)
         startOk && rapid_time_check_disable_flag && !ratioBad
         && !program_setting_error_flag |=> !program_setting_error_flag;
   endproperty
   a_nochk: assert property (p_nochk)
      else $error("error raised with check disabled");

   property p_clamp;
      @(posedge clock) disable iff (!rstn)
         startOk |=> target_reg <= lim_reg;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("target above speed limit");

   property p_ratio;
      @(posedge clock) disable iff (!rstn)
         startOk && ratioBad && profNext != AAP_ADV
         |=> profileMode == AAP_TRAP && sRatioActive == 8'h00;
   endproperty
   a_ratio: assert property (p_ratio)
      else $error("bad ratio not trapezoid");

   property p_adv;
      @(posedge clock) disable iff (!rstn)
         prof_reg == AAP_ADV |-> sRatioActive == 8'h00;
   endproperty
   a_adv: assert property (p_adv)
      else $error("ratio used in advanced mode");

   property p_fixed;
      @(posedge clock) disable iff (!rstn)
         startOk && fixed_time_accel_method |=> prof_reg != AAP_ADV;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("advanced used with fixed time");

   property p_stop;
      @(posedge clock) disable iff (!rstn)
         state_reg == AAP_ACCEL && stopReq |=> state_reg == AAP_DECEL;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not decelerate");

   property p_dflt;
      @(posedge clock) disable iff (!rstn)
         startOk && !moveSetValid |=> torqueLimit == $past(trqSet[0]);
   endproperty
   a_dflt: assert property (p_dflt)
      else $error("default set not used");

   property p_hold;
      @(posedge clock) disable iff (!rstn)
         state_reg != AAP_IDLE && !startOk |=> $stable(lim_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("parameters changed mid move");

   c_move: cover property (@(posedge clock) startOk ##[1:50] moving);
   c_err: cover property (@(posedge clock) program_setting_error_flag);
   c_regen: cover property (@(posedge clock) regenPulse);
   c_scurve: cover property (@(posedge clock) profileMode == AAP_SCURVE);
endmodule
`default_nettype wire

//--- tb/aap_servo_model.sv
`timescale 1ns/1ps
`default_nettype none
// Amplifier side: follows the speed command and keeps the peak of each move
module aap_servo_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [31:0] speedCmd,
   input wire logic moving,
   output logic [31:0] peakSpeed
);
   logic movingReg;

   // Peak restarts on each move, so a stale peak cannot hide an overshoot
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         peakSpeed <= 32'h0;
         movingReg <= 1'b0;
      end else begin
         movingReg <= moving;
         if (moving && !movingReg) begin
            peakSpeed <= speedCmd;
         end else if (speedCmd > peakSpeed) begin
            peakSpeed <= speedCmd;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import aap_pkg::*;
   localparam int CPM = 4;
   localparam int LIMIT = 40000;
   typedef struct packed {
      logic [1:0] cs;
      logic [31:0] lim;
      logic [15:0] acc, dec, rap;
      logic [7:0] sr;
      logic adv, sur, fix, dis;
      logic [1:0] src;
      logic [10:0] tq;
      logic [16:0] tol;
      logic [31:0] spd;
      logic [1:0] eMode;
      logic [7:0] eSr, eErr;
      logic [10:0] eTq;
      logic [16:0] eTol;
   } aap_row_t;
   // Source 0 stop, 1 forward limit, 2 reverse limit, 3 rapid stop
   localparam aap_row_t ROWS[8] = '{
      '{2'h0, 32'h7D0, 16'hA, 16'hA, 16'h5, 8'h0, 1'b0, 1'b0, 1'b0, 1'b0,
        2'h0, 11'h12C, 17'h64, 32'hFA0, 2'h0, 8'h0, 8'h0, 11'h12C, 17'h64},
      '{2'h1, 32'h30D40, 16'h3E8, 16'h3E8, 16'hFA, 8'h32, 1'b0, 1'b1,
        1'b0, 1'b0, 2'h1, 11'h5DC, 17'h1FFFF, 32'h3E8, 2'h1, 8'h32, 8'h0,
        11'h3E8, 17'h186A0},
      '{2'h2, 32'h30D40, 16'h3E8, 16'h3E8, 16'h7D0, 8'h0, 1'b0, 1'b0,
        1'b0, 1'b0, 2'h3, 11'h1F4, 17'h0, 32'h3E8, 2'h0, 8'h0, 8'h33,
        11'h1F4, 17'h0},
      '{2'h3, 32'h30D40, 16'h3E8, 16'h3E8, 16'h7D0, 8'h0, 1'b0, 1'b0,
        1'b0, 1'b1, 2'h3, 11'h3E8, 17'h186A0, 32'h3E8, 2'h0, 8'h0, 8'h0,
        11'h3E8, 17'h186A0},
      '{2'h0, 32'h30D40, 16'h3E8, 16'h3E8, 16'hFA, 8'h65, 1'b0, 1'b1,
        1'b0, 1'b0, 2'h2, 11'h1, 17'h0, 32'h3E8, 2'h0, 8'h0, 8'h34,
        11'h1, 17'h0},
      '{2'h1, 32'h30D40, 16'h3E8, 16'h3E8, 16'h7D0, 8'h32, 1'b1, 1'b0,
        1'b0, 1'b1, 2'h3, 11'h12C, 17'h64, 32'h3E8, 2'h2, 8'hFF, 8'h0,
        11'h12C, 17'h64},
      '{2'h2, 32'h30D40, 16'h3E8, 16'h3E8, 16'h3E8, 8'h0, 1'b1, 1'b0,
        1'b1, 1'b0, 2'h0, 11'h12C, 17'h64, 32'h3E8, 2'h0, 8'h0, 8'h0,
        11'h12C, 17'h64},
      '{2'h3, 32'h30D40, 16'h3E8, 16'h3E8, 16'h3E8, 8'h64, 1'b0, 1'b0,
        1'b0, 1'b0, 2'h0, 11'h12C, 17'h64, 32'h3E8, 2'h1, 8'h64, 8'h0,
        11'h12C, 17'h64}};

   logic clock, rstn, cfgWrite, cfgAdvanced, cfgStopUsesRapid, moveStart;
   logic moveSetValid, fixed_time_accel_method, errorClear, stopPin;
   logic rapid_time_check_disable_flag, forward_limit_input, skipPin;
   logic reverse_limit_input, rapidStopPin, moving, regenPulse;
   logic program_setting_error_flag, seen;
   logic [1:0] cfgSet, moveSet, profileMode;
   logic [31:0] cfgSpeedLimit, moveSpeed, speedCmd, peakSpeed;
   logic [15:0] cfgAccelTime, cfgDecelTime, cfgRapidTime;
   logic [7:0] cfgSRatio, sRatioActive, error_detail_word;
   logic [10:0] cfgTorque, torqueLimit;
   logic [16:0] cfgArcTol, arcTolerance;
   int n_errors, cmp_count, cyc;
   aap_row_t r;

   aap_axis_accel_profile #(.CYC_PER_MS(CPM)) DUT (
      .clock, .rstn, .cfgWrite, .cfgSet, .cfgSpeedLimit, .cfgAccelTime,
      .cfgDecelTime, .cfgRapidTime, .cfgSRatio, .cfgAdvanced,
      .cfgStopUsesRapid, .cfgTorque, .cfgArcTol, .moveStart, .moveSetValid,
      .moveSet, .moveSpeed, .fixed_time_accel_method,
      .rapid_time_check_disable_flag, .errorClear, .stopPin,
      .forward_limit_input, .reverse_limit_input, .rapidStopPin, .skipPin,
      .speedCmd, .moving, .torqueLimit, .arcTolerance, .profileMode,
      .sRatioActive, .regenPulse, .error_detail_word,
      .program_setting_error_flag);

   aap_servo_model servo (.clock, .rstn, .speedCmd, .moving, .peakSpeed);

   always #2.5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hung handshake must still reach the verdict
   always @(posedge clock) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_errors++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // Ramp length in ms ticks; slack covers start latency and sync stages
   task automatic chk_ticks(input int n, input int ticks);
      cmp_count++;
      if (n < ticks * CPM - 4 || n > ticks * CPM + 8) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, n, ticks * CPM);
      end
   endtask

   task automatic cfg(input aap_row_t c);
      @(negedge clock);
      {cfgWrite, cfgSet, cfgSpeedLimit, cfgAccelTime} = {1'b1, c.cs, c.lim, c.acc};
      {cfgDecelTime, cfgRapidTime, cfgSRatio} = {c.dec, c.rap, c.sr};
      {cfgAdvanced, cfgStopUsesRapid, cfgTorque} = {c.adv, c.sur, c.tq};
      cfgArcTol = c.tol;
      @(negedge clock);
      cfgWrite = 1'b0;
      errorClear = 1'b1;
      @(negedge clock);
      errorClear = 1'b0;
   endtask

   task automatic start(input logic v, input logic [1:0] s,
                        input logic [31:0] spd, input logic f, input logic d);
      @(negedge clock);
      {moveStart, moveSetValid, moveSet, moveSpeed} = {1'b1, v, s, spd};
      {fixed_time_accel_method, rapid_time_check_disable_flag} = {f, d};
      @(negedge clock);
      moveStart = 1'b0;
      @(negedge clock);
   endtask

   task automatic pins(input logic [1:0] s, input logic v);
      @(negedge clock);
      case (s)
         2'h0: stopPin = v;
         2'h1: forward_limit_input = v;
         2'h2: reverse_limit_input = v;
         default: rapidStopPin = v;
      endcase
   endtask

   task automatic wait_speed(input logic [31:0] v);
      for (int i = 0; i < 3000 && speedCmd !== v; i++) @(negedge clock);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 3000 && moving !== 1'b0; i++) @(negedge clock);
   endtask

   task automatic run_row(input aap_row_t c);
      logic [31:0] tgt;
      logic [31:0] stp;
      logic [15:0] tm;
      int t0;
      tgt = (c.spd > c.lim) ? c.lim : c.spd;
      tm = c.dec;
      if (c.src == 2'h3 || c.sur) begin
         tm = (c.rap > c.dec && (!c.dis || c.adv)) ? c.dec : c.rap;
      end
      cfg(c);
      t0 = cyc;
      start(1'b1, c.cs, c.spd, c.fix, c.dis);
      chk(torqueLimit, c.eTq);
      chk(arcTolerance, c.eTol);
      chk(profileMode, c.eMode);
      if (c.eSr !== 8'hFF) chk(sRatioActive, c.eSr);
      chk(error_detail_word, c.eErr);
      chk(program_setting_error_flag, c.eErr != 8'h0);
      wait_speed(tgt);
      chk(speedCmd, tgt);
      stp = c.lim / c.acc;
      if (c.eMode == 2'h0) chk_ticks(cyc - t0, (tgt + stp - 1) / stp);
      t0 = cyc;
      pins(c.src, 1'b1);
      wait_idle();
      stp = c.lim / tm;
      if (c.eMode == 2'h0) chk_ticks(cyc - t0, (tgt + stp - 1) / stp);
      chk(speedCmd, 32'h0);
      chk(peakSpeed, tgt);
      pins(c.src, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {clock, rstn, cfgWrite, cfgSet, cfgSpeedLimit, cfgAccelTime} = '0;
      {cfgDecelTime, cfgRapidTime, cfgSRatio, cfgAdvanced} = '0;
      {cfgStopUsesRapid, cfgTorque, cfgArcTol, moveStart, moveSetValid} = '0;
      {moveSet, moveSpeed, fixed_time_accel_method, errorClear} = '0;
      {rapid_time_check_disable_flag, stopPin, forward_limit_input} = '0;
      {reverse_limit_input, rapidStopPin, skipPin} = '0;
      {n_errors, cmp_count, cyc} = '0;
      repeat (4) @(negedge clock);
      rstn = 1'b1;
      foreach (ROWS[i]) run_row(ROWS[i]);
      // No set named: set one is used; a start while moving is refused
      r = ROWS[0];
      r.tq = 11'h1F4;
      cfg(r);
      r.cs = 2'h3;
      r.tq = 11'h2BC;
      cfg(r);
      start(1'b0, 2'h3, 32'h3E8, 1'b0, 1'b0);
      chk(torqueLimit, 11'h1F4);
      r.cs = 2'h0;
      r.tq = 11'h64;
      cfg(r);
      start(1'b1, 2'h3, 32'h3E8, 1'b0, 1'b0);
      chk(torqueLimit, 11'h1F4);
      chk(moving, 1'b1);
      // Reset in mid-move returns every output to its idle value
      @(negedge clock);
      rstn = 1'b0;
      @(negedge clock);
      chk(speedCmd, 32'h0);
      chk({moving, profileMode}, 3'h0);
      chk(torqueLimit, 11'h12C);
      chk(arcTolerance, 17'h64);
      chk({error_detail_word, program_setting_error_flag}, 9'h0);
      rstn = 1'b1;
      // Rapid stop during S-curve deceleration rebuilds the pattern
      r = ROWS[7];
      r.spd = 32'hFA0;
      cfg(r);
      start(1'b1, r.cs, r.spd, 1'b0, 1'b0);
      wait_speed(32'hFA0);
      pins(2'h0, 1'b1);
      repeat (12) @(negedge clock);
      pins(2'h3, 1'b1);
      seen = 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(negedge clock);
         if (regenPulse === 1'b1) seen = 1'b1;
      end
      chk(seen, 1'b1);
      wait_idle();
      chk(speedCmd, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
